/* hdl/clpd_pkg.sv */
// Notes on behaviour
// RL1: evaluate three phase magnitudes every 5 ms
// RL2: release at 97 % of each threshold
// RL3: shared settings, per-phase comparison
// RL4: any exceeding phase triggers pick-up evaluation
// RL5: low condition when all phases below low
// RL6: high condition when all phases above high
// RL7: any phase over overcurrent drops active now
// RL8: settings change live without restart
// RL9: five-valued condition field readable
// RL10: block input sampled at each cycle start
// RL11: unblocked pick-up asserts active, runs timers
// RL12: blocked pick-up flags blocked, no processing
// RL13: blocking while active releases like pick-up reset
// RL14: source asserts block 5 ms before delay ends
// RL15: low must last start delay before active
// RL16: high lasting maximum time releases active
// RL17: active held at least minimum time before in-band release
// RL18: current back in band ends start-up
// RL19: timers count ticks, clear on dropout
`default_nettype none

package clpd_pkg;

    // magnitudes and thresholds in units of 0.01 x rated current
    localparam int unsigned MAG_W         = 16;
    localparam int unsigned TMR_W         = 19;  // up to 1800 s in 5 ms ticks
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned TICK_MS       = 5;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned RESET_PCT     = 97;
    localparam logic [MAG_W-1:0] LOW_DEF  = 16'h0014;  // 0.20 x In
    localparam logic [MAG_W-1:0] HIGH_DEF = 16'h0078;  // 1.20 x In
    localparam logic [MAG_W-1:0] OVER_DEF = 16'h00C8;  // 2.00 x In
    localparam logic [TMR_W-1:0] TSET_DEF = 19'h0_07D0; // 10 s
    localparam logic [TMR_W-1:0] TMAX_DEF = 19'h0_1770; // 30 s
    localparam logic [TMR_W-1:0] TMIN_DEF = 19'h0_0008; // 40 ms

    typedef struct packed {
        logic [MAG_W-1:0] a;
        logic [MAG_W-1:0] b;
        logic [MAG_W-1:0] c;
    } clpd_phases_t;

    typedef struct packed {
        logic [MAG_W-1:0] low;
        logic [MAG_W-1:0] high;
        logic [MAG_W-1:0] over;
        logic [TMR_W-1:0] t_set;
        logic [TMR_W-1:0] t_max;
        logic [TMR_W-1:0] t_min;
    } clpd_settings_t;

    typedef enum logic [2:0] {
        CLPD_COND_NORMAL  = 3'h0,
        CLPD_COND_LOW     = 3'h1,
        CLPD_COND_OVER    = 3'h2,
        CLPD_COND_ACTIVE  = 3'h3,
        CLPD_COND_BLOCKED = 3'h4
    } clpd_cond_t;

    typedef enum logic [2:0] {
        CLPD_ST_IDLE    = 3'b001,
        CLPD_ST_ACTIVE  = 3'b010,
        CLPD_ST_BLOCKED = 3'b100
    } clpd_state_t;

endpackage

`default_nettype wire

/* hdl/clpd_detector.sv */
`default_nettype none

module clpd_detector (
    input  wire logic                    clock,     // 100 MHz
    input  wire logic                    nrst,      // async reset, active low
    input  wire logic                    clk_en,    // freezes all state when low
    input  wire clpd_pkg::clpd_phases_t  phases,    // phase rms magnitudes
    input  wire logic                    sample,    // fresh magnitude set present
    input  wire clpd_pkg::clpd_settings_t settings, // live settings
    input  wire logic                    block_in,  // blocking matrix input
    output logic                         cold_load_active,   // active output
    output logic                         blocked,            // blocked indication
    output clpd_pkg::clpd_cond_t         detector_condition, // condition field
    output logic                         low_start,          // low condition
    output logic                         high_start,         // high condition
    output logic                         over_start          // overcurrent condition
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // release level: 97 % of setting, rounded down
    function automatic logic [clpd_pkg::MAG_W-1:0] rel_level(input logic [clpd_pkg::MAG_W-1:0] s);
        logic [clpd_pkg::MAG_W+7:0] p;
        p = {8'h00, s} * 24'(clpd_pkg::RESET_PCT);
        return clpd_pkg::MAG_W'(p / 24'd100);
    endfunction

    // upward hysteresis compare for one phase
    function automatic logic hys_above(input logic prev, input logic [clpd_pkg::MAG_W-1:0] m,
                                       input logic [clpd_pkg::MAG_W-1:0] s);
        return prev ? (m > rel_level(s)) : (m > s);
    endfunction

    // saturating timer step
    function automatic logic [clpd_pkg::TMR_W-1:0] tstep(input logic run, input logic [clpd_pkg::TMR_W-1:0] t);
        return !run ? '0 : ((&t) ? t : t + 1'b1);
    endfunction

    // ------------------------------------------------------------
    // evaluation tick
    // ------------------------------------------------------------
    logic [23:0] tick_cnt;
    logic [23:0] next_tick_cnt;
    logic        tick;

    // internal 5 ms base; an external fresh-sample strobe also counts as a tick
    always_comb begin
        tick          = sample || (tick_cnt == 24'(clpd_pkg::TICK_CYCLES - 1)); // RL1
        next_tick_cnt = tick ? 24'h00_0000 : tick_cnt + 24'h00_0001;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tick_cnt <= '0;
        end else if (clk_en) begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // ------------------------------------------------------------
    // threshold comparison
    // ------------------------------------------------------------
    logic [2:0] hi_ph, ov_ph, lo_ph;          // per-phase flags; lo_ph = above low
    logic [2:0] next_hi_ph, next_ov_ph, next_lo_ph;
    logic [clpd_pkg::MAG_W-1:0] m [3];
    logic       blk;
    logic       next_blk;

    // every phase uses the same setting but its own flag
    always_comb begin
        m[0] = phases.a;
        m[1] = phases.b;
        m[2] = phases.c;
        for (int i = 0; i < 3; i++) begin
            next_hi_ph[i] = hys_above(hi_ph[i], m[i], settings.high); // RL2 RL3
            next_ov_ph[i] = hys_above(ov_ph[i], m[i], settings.over); // RL2 RL3
            next_lo_ph[i] = hys_above(lo_ph[i], m[i], settings.low);  // RL2 RL3
        end
        next_blk = block_in; // RL10
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hi_ph <= '0;
            ov_ph <= '0;
            lo_ph <= '0;
            blk   <= 1'b0;
        end else if (clk_en && tick) begin
            hi_ph <= next_hi_ph;
            ov_ph <= next_ov_ph;
            lo_ph <= next_lo_ph;
            blk   <= next_blk;
        end
    end

    // condition levels used by the sequencer on the same tick
    logic low_now, high_now, over_now;
    always_comb begin
        low_now  = ~|next_lo_ph;  // RL5
        high_now = &next_hi_ph;   // RL6
        over_now = |next_ov_ph;   // RL4 RL7
    end

    // ------------------------------------------------------------
    // sequencer and timers
    // ------------------------------------------------------------
    clpd_pkg::clpd_state_t state, next_state;
    logic [clpd_pkg::TMR_W-1:0] t_low, t_high, t_act;
    logic [clpd_pkg::TMR_W-1:0] next_t_low, next_t_high, next_t_act;
    logic inrush_seen, next_inrush_seen;
    logic picked;

    // settings are read every tick, so changes take effect without restart
    always_comb begin
        next_state       = state;
        next_inrush_seen = inrush_seen;
        next_t_low       = tstep(low_now, t_low);        // RL19 RL8
        next_t_high      = '0;
        next_t_act       = '0;
        // saturating step avoids a wrap that would drop a long low period
        picked           = low_now && (next_t_low >= settings.t_set || settings.t_set == '0); // RL15
        unique case (state)
            clpd_pkg::CLPD_ST_IDLE: begin
                if (picked) begin
                    if (next_blk) begin
                        next_state = clpd_pkg::CLPD_ST_BLOCKED; // RL12
                    end else begin
                        next_state       = clpd_pkg::CLPD_ST_ACTIVE; // RL11
                        next_inrush_seen = 1'b0;
                    end
                end
            end
            clpd_pkg::CLPD_ST_ACTIVE: begin
                next_t_act  = tstep(1'b1, t_act);
                next_t_high = tstep(high_now, t_high);   // RL19
                if (high_now) begin
                    next_inrush_seen = 1'b1;
                end
                if (over_now || next_blk) begin
                    next_state = clpd_pkg::CLPD_ST_IDLE; // RL7 RL13
                end else if (high_now && next_t_high >= settings.t_max) begin
                    next_state = clpd_pkg::CLPD_ST_IDLE; // RL16
                end else if (!high_now && !low_now && next_t_act >= settings.t_min) begin
                    next_state = clpd_pkg::CLPD_ST_IDLE; // RL17 RL18
                end
            end
            clpd_pkg::CLPD_ST_BLOCKED: begin
                if (!next_blk || !low_now) begin
                    next_state = clpd_pkg::CLPD_ST_IDLE; // RL12
                end
            end
            default: next_state = clpd_pkg::CLPD_ST_IDLE;
        endcase
        if (next_state == clpd_pkg::CLPD_ST_IDLE && state != clpd_pkg::CLPD_ST_IDLE) begin
            next_t_low = '0; // a fresh low period is needed to re-arm
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state       <= clpd_pkg::CLPD_ST_IDLE;
            t_low       <= '0;
            t_high      <= '0;
            t_act       <= '0;
            inrush_seen <= 1'b0;
        end else if (clk_en && tick) begin
            state       <= next_state;
            t_low       <= next_t_low;
            t_high      <= next_t_high;
            t_act       <= next_t_act;
            inrush_seen <= next_inrush_seen;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    clpd_pkg::clpd_cond_t next_cond;

    // priority: blocked, active, overcurrent, low, normal
    always_comb begin
        if (state == clpd_pkg::CLPD_ST_BLOCKED) begin
            next_cond = clpd_pkg::CLPD_COND_BLOCKED; // RL9
        end else if (state == clpd_pkg::CLPD_ST_ACTIVE) begin
            next_cond = clpd_pkg::CLPD_COND_ACTIVE;
        end else if (|ov_ph) begin
            next_cond = clpd_pkg::CLPD_COND_OVER;
        end else if (~|lo_ph) begin
            next_cond = clpd_pkg::CLPD_COND_LOW;
        end else begin
            next_cond = clpd_pkg::CLPD_COND_NORMAL;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            detector_condition <= clpd_pkg::CLPD_COND_NORMAL;
        end else if (clk_en) begin
            detector_condition <= next_cond;
        end
    end

    // state and flags are registers, so these outputs are decoded from registered values only
    always_comb begin
        cold_load_active = (state == clpd_pkg::CLPD_ST_ACTIVE);
        blocked          = (state == clpd_pkg::CLPD_ST_BLOCKED);
        low_start        = ~|lo_ph;
        high_start       = &hi_ph;
        over_start       = |ov_ph;
    end

endmodule

`default_nettype wire

/* sim/clpd_front.sv */
`default_nettype none
// ---------------------------------------------
// measurement front end model
// ---------------------------------------------
module clpd_front (
    input  wire logic                   clock,  // evaluation clock
    input  wire logic                   nrst,   // async reset, active low
    input  wire logic                   req,    // bench wants a new set
    input  wire clpd_pkg::clpd_phases_t mag,    // magnitudes to present
    output clpd_pkg::clpd_phases_t      phases, // held magnitudes
    output logic                        sample  // fresh-set pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // sample follows req one cycle later, so a one-cycle request gives exactly one fresh set
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phases <= '0;
            sample <= 1'b0;
        end else begin
            sample <= req;
            if (req) begin
                phases <= mag;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/clpd_properties.sv */
`default_nettype none
// ---------------------------------------------
// port checker
// ---------------------------------------------
module clpd_properties (
    input wire logic                     clock,              // clock
    input wire logic                     nrst,               // reset
    input wire logic                     clk_en,             // enable
    input wire clpd_pkg::clpd_phases_t   phases,             // magnitudes
    input wire logic                     sample,             // fresh set
    input wire clpd_pkg::clpd_settings_t settings,           // settings
    input wire logic                     block_in,           // block
    input wire logic                     cold_load_active,   // active
    input wire logic                     blocked,            // blocked
    input wire clpd_pkg::clpd_cond_t     detector_condition, // condition
    input wire logic                     low_start,          // low flag
    input wire logic                     high_start,         // high flag
    input wire logic                     over_start          // over flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        tk;
    logic [31:0] lo97;
    logic [31:0] hi97;
    // internal tick is 500000 cycles away, so only sample pulses count here
    assign tk = clk_en & sample;
    assign lo97 = settings.low * 32'd97 / 32'd100;
    assign hi97 = settings.high * 32'd97 / 32'd100;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_hold; !$past(tk) |-> $stable(cold_load_active) && $stable(blocked); endproperty
    a_hold: assert property (p_hold) else $error("output moved off tick");
    property p_over; tk && (phases.a > settings.over) |=> !cold_load_active && over_start; endproperty
    a_over: assert property (p_over) else $error("overcurrent kept active");
    property p_lowoff; tk && (phases.b > settings.low) |=> !low_start; endproperty
    a_lowoff: assert property (p_lowoff) else $error("low flag with phase above");
    property p_low; tk && phases.a <= lo97 && phases.b <= lo97 && phases.c <= lo97 |=> low_start; endproperty
    a_low: assert property (p_low) else $error("low flag missing");
    property p_high; tk && phases.a > settings.high && phases.b > settings.high && phases.c > settings.high
        |=> high_start; endproperty
    a_high: assert property (p_high) else $error("high flag missing");
    property p_highoff; tk && phases.c <= hi97 |=> !high_start; endproperty
    a_highoff: assert property (p_highoff) else $error("high flag held");
    property p_block; tk && block_in |=> !cold_load_active; endproperty
    a_block: assert property (p_block) else $error("active while blocked");
    property p_excl; cold_load_active |-> !blocked; endproperty
    a_excl: assert property (p_excl) else $error("active and blocked");
    property p_cond; cold_load_active |=> detector_condition == clpd_pkg::CLPD_COND_ACTIVE; endproperty
    a_cond: assert property (p_cond) else $error("condition not active");
    property p_rise; $rose(cold_load_active) |-> $past(tk && !block_in); endproperty
    a_rise: assert property (p_rise) else $error("activation without clear tick");
    c_act: cover property ($rose(cold_load_active));
    c_blk: cover property ($rose(blocked));
    c_ovr: cover property (tk && phases.a > settings.over);
endmodule
bind clpd_detector clpd_properties clpd_properties_inst (.clock(clock), .nrst(nrst), .clk_en(clk_en),
    .phases(phases), .sample(sample), .settings(settings), .block_in(block_in),
    .cold_load_active(cold_load_active), .blocked(blocked), .detector_condition(detector_condition),
    .low_start(low_start), .high_start(high_start), .over_start(over_start));
`default_nettype wire

/* sim/test_cold_load_pickup_detector.sv */
`default_nettype none
module test_cold_load_pickup_detector;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clock, nrst, clk_en, block_in, req, sample, act, blk, lo, hi, ov;
    clpd_pkg::clpd_phases_t   mag, phases;
    clpd_pkg::clpd_settings_t settings;
    clpd_pkg::clpd_cond_t     cond;
    int                       n_mismatch, tests_run, cycles;
    clpd_front clpd_front_inst (.clock(clock), .nrst(nrst), .req(req), .mag(mag), .phases(phases), .sample(sample));
    clpd_detector clpd_detector_inst (.clock(clock), .nrst(nrst), .clk_en(clk_en), .phases(phases),
        .sample(sample), .settings(settings), .block_in(block_in), .cold_load_active(act), .blocked(blk),
        .detector_condition(cond), .low_start(lo), .high_start(hi), .over_start(ov));
    // ---------------------------------------------
    // shared tasks
    // ---------------------------------------------
    task automatic check(input string nm, input logic [2:0] seen, input logic [2:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // block level is set with the request, well before the tick edge
    task automatic tick(input logic [15:0] ma, input logic [15:0] mbc, input logic bk);
        @(posedge clock);
        #1 req = 1'b1;
        mag = {ma, mbc, mbc};
        block_in = bk;
        @(posedge clock);
        #1 req = 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic s_start;
        repeat (2) tick(16'h000A, 16'h000A, 1'b0);
        check("act", act, 1'b0);
        check("lo", lo, 1'b1);
        check("cond", cond, clpd_pkg::CLPD_COND_LOW);
        tick(16'h000A, 16'h000A, 1'b0);
        check("act", act, 1'b1);
        check("cond", cond, clpd_pkg::CLPD_COND_ACTIVE);
    endtask
    task automatic s_over;
        clk_en = 1'b0;
        tick(16'h00FA, 16'h000A, 1'b0);
        check("act", act, 1'b1);
        clk_en = 1'b1;
        tick(16'h00FA, 16'h000A, 1'b0);
        check("act", act, 1'b0);
        check("ov", ov, 1'b1);
        check("cond", cond, clpd_pkg::CLPD_COND_OVER);
    endtask
    task automatic s_max;
        settings.t_set = 19'h0_0000;
        tick(16'h000A, 16'h000A, 1'b0);
        check("act", act, 1'b1);
        repeat (2) tick(16'h0096, 16'h0096, 1'b0);
        check("hi", hi, 1'b1);
        check("act", act, 1'b1);
        tick(16'h0096, 16'h0096, 1'b0);
        check("act", act, 1'b0);
    endtask
    task automatic s_min;
        settings.t_min = 19'h0_0004;
        tick(16'h000A, 16'h000A, 1'b0);
        tick(16'h0032, 16'h0032, 1'b0);
        check("act", act, 1'b1);
        repeat (5) tick(16'h0032, 16'h0032, 1'b0);
        check("act", act, 1'b0);
    endtask
    task automatic s_hyst;
        settings.high = 16'h0064;
        tick(16'h0065, 16'h0065, 1'b0);
        tick(16'h0062, 16'h0062, 1'b0);
        check("hi", hi, 1'b1);
        tick(16'h0061, 16'h0061, 1'b0);
        check("hi", hi, 1'b0);
        check("cond", cond, clpd_pkg::CLPD_COND_NORMAL);
        settings.high = clpd_pkg::HIGH_DEF;
    endtask
    task automatic s_block;
        tick(16'h000A, 16'h000A, 1'b1);
        check("blk", blk, 1'b1);
        check("cond", cond, clpd_pkg::CLPD_COND_BLOCKED);
        tick(16'h0032, 16'h0032, 1'b0);
        tick(16'h000A, 16'h000A, 1'b0);
        check("act", act, 1'b1);
        tick(16'h000A, 16'h000A, 1'b1);
        check("act", act, 1'b0);
    endtask
    // free-running clock and hang guard
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            test_done();
        end
    end
    // main sequence
    initial begin
        {nrst, req, block_in, mag} = '0;
        clk_en = 1'b1;
        settings = {clpd_pkg::LOW_DEF, clpd_pkg::HIGH_DEF, clpd_pkg::OVER_DEF, 19'h0_0003, 19'h0_0003, 19'h0_0000};
        repeat (10) @(posedge clock);
        #1 nrst = 1'b1;
        s_start();
        s_over();
        s_max();
        s_min();
        s_hyst();
        s_block();
        test_done();
    end
endmodule
`default_nettype wire
